// ==== logic/eeprom_pkg.sv ====
// Purpose: constants, types and state layout of the eeprom access controller
// Assumes: 125 MHz system clock, APB word-indexed register map
// Notes: register index times four is the APB byte address
package eeprom_pkg;

	localparam int          CLK_PERIOD_NS = 8;
	localparam int          QUARTER_NS    = 2500;
	localparam int          QUARTER_CYC_I = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [8:0]  QUARTER_LAST  = 9'(QUARTER_CYC_I - 1);

	localparam logic [5:0]  IDX_LOC_LOW   = 6'h09;
	localparam logic [5:0]  IDX_LOC_HIGH  = 6'h0A;
	localparam logic [5:0]  IDX_BUFFER    = 6'h0B;
	localparam logic [5:0]  IDX_CTRL      = 6'h0C;
	localparam logic [5:0]  IDX_TEST      = 6'h0D;
	localparam logic [5:0]  IDX_GAIN      = 6'h0E;
	localparam logic [5:0]  IDX_BIAS      = 6'h0F;
	localparam logic [5:0]  IDX_SYSCLK_RUNNING_FLAG    = 6'h1F;

	localparam int          CTRL_ERR_BIT   = 5;
	localparam int          CTRL_BUSY_BIT  = 4;
	localparam int          CTRL_ABORT_BIT = 3;
	localparam int          CTRL_START_BIT = 2;

	localparam logic [7:0]  GAIN_MASK      = 8'h0F;
	localparam logic [7:0]  BIAS_MASK      = 8'h3F;
	localparam logic [3:0]  EE_DEVICE_CODE = 4'hA;
	localparam logic [10:0] EE_LOC_GAIN    = 11'h000;
	localparam logic [10:0] EE_LOC_BIAS    = 11'h001;

	localparam logic [2:0]  STEP_FIRST     = 3'd0;
	localparam logic [2:0]  STEP_DEV_WR    = 3'd1;
	localparam logic [2:0]  STEP_WORD      = 3'd2;
	localparam logic [2:0]  STEP_DATA0     = 3'd3;
	localparam logic [2:0]  STEP_DATA1     = 3'd4;
	localparam logic [2:0]  STEP_RX0       = 3'd5;
	localparam logic [2:0]  STEP_RX1       = 3'd6;
	localparam logic [3:0]  ACK_BIT        = 4'd8;

	typedef enum logic [1:0] {
		OP_READ_BYTE  = 2'b00,
		OP_WRITE_BYTE = 2'b01,
		OP_LOAD_CFG   = 2'b10,
		OP_STORE_CFG  = 2'b11
	} op_t;

	typedef enum logic [2:0] {
		FSM_IDLE  = 3'b000,
		FSM_START = 3'b001,
		FSM_TX    = 3'b011,
		FSM_RX    = 3'b010,
		FSM_STOP  = 3'b110
	} fsm_t;

	typedef struct packed {
		logic       clock_line;
		logic       data_out;
		logic       data_oe;
	} eeprom_link_t;

	typedef struct packed {
		logic [1:0] pre_gain;
		logic [1:0] adc_gain;
		logic       bias_switch_first;
		logic       bias_switch_second;
		logic [3:0] pre_bias;
	} analog_cfg_t;

	typedef struct packed {
		fsm_t       fsm;
		logic [1:0] ph;
		logic [8:0] qcnt;
		logic [3:0] bitn;
		logic [2:0] step;
		logic [7:0] sh;
		op_t        op;
		logic       busy;
		logic       fail;
		logic       err;
		logic [1:0] sync;
		logic [7:0] location_low;
		logic [7:0] location_high;
		logic [7:0] buffer;
		logic [7:0] test;
		logic [7:0] gain;
		logic [7:0] bias;
		logic       sysclk_running_flag;
		logic [7:0] prdata;
		logic       scl;
		logic       sda_oe;
	} ctrl_state_t;

	localparam ctrl_state_t STATE_RESET = '{
		fsm:     FSM_IDLE,
		op:      OP_READ_BYTE,
		sync:    2'h3,
		sysclk_running_flag:  1'b1,
		scl:     1'b1,
		default: '0
	};

endpackage

// ==== logic/eeprom_master_access_ctrl.sv ====
// Purpose: two-wire master that moves bytes between registers and a serial eeprom
// Assumes: APB slave with zero wait states, open-drain data line with pull-up
// Notes: clock line is pushed, no clock stretching from the memory is honoured
`timescale 1ns/1ps
module eeprom_master_access_ctrl (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   eeprom_data_line_in,
	output eeprom_pkg::eeprom_link_t    eeprom_link,
	output eeprom_pkg::analog_cfg_t     analog_cfg
);
	import eeprom_pkg::*;

	ctrl_state_t s;
	ctrl_state_t n;

	logic [5:0]  idx;
	logic        mapped;
	logic        acc_w;
	logic        ctrl_w;
	logic        abort;
	logic        start;
	logic        err_clr;
	logic        err_set;
	logic        qdone;
	logic        sda_s;
	logic        last_rx;
	logic        drive;
	logic [10:0] loc;
	logic [7:0]  rbyte;

	always_comb begin
		n       = s;
		idx     = paddr[7:2];
		mapped  = (paddr[1:0] == 2'h0) && (idx == IDX_LOC_LOW || idx == IDX_LOC_HIGH
			|| idx == IDX_BUFFER || idx == IDX_CTRL || idx == IDX_TEST || idx == IDX_GAIN
			|| idx == IDX_BIAS || idx == IDX_SYSCLK_RUNNING_FLAG);
		acc_w   = psel & penable & pwrite & mapped;
		ctrl_w  = acc_w & (idx == IDX_CTRL);
		abort   = ctrl_w & pwdata[CTRL_ABORT_BIT];
		// a start during an access or with the system clock stopped is dropped
		start   = ctrl_w & pwdata[CTRL_START_BIT] & ~abort & ~s.busy & s.sysclk_running_flag;
		err_clr = ctrl_w & pwdata[CTRL_ERR_BIT];
		err_set = 1'b0;
		sda_s   = s.sync[1];
		loc     = s.op[1] ? EE_LOC_GAIN : {s.location_low[2:0], s.location_high};
		last_rx = (s.step == STEP_RX1) || !s.op[1];
		qdone   = (s.qcnt == QUARTER_LAST);
		drive   = 1'b1;

		// read data is captured in the setup cycle so it comes from a flop
		unique case (idx)
			IDX_LOC_LOW:  rbyte = s.location_low;
			IDX_LOC_HIGH: rbyte = s.location_high;
			IDX_BUFFER:   rbyte = s.buffer;
			IDX_CTRL:     rbyte = {2'h0, s.err, s.busy, 4'h0};
			IDX_TEST:     rbyte = s.test;
			IDX_GAIN:     rbyte = s.gain;
			IDX_BIAS:     rbyte = s.bias;
			IDX_SYSCLK_RUNNING_FLAG:   rbyte = {7'h0, s.sysclk_running_flag};
			default:      rbyte = 8'h00;
		endcase
		if (psel && !penable) begin
			n.prdata = mapped ? rbyte : 8'h00;
		end

		n.sync = {s.sync[0], eeprom_data_line_in};

		if (acc_w) begin
			unique case (idx)
				IDX_LOC_LOW:  n.location_low  = pwdata[7:0];
				IDX_LOC_HIGH: n.location_high = pwdata[7:0];
				IDX_BUFFER:   n.buffer        = pwdata[7:0];
				IDX_TEST:     n.test          = pwdata[7:0];
				IDX_GAIN:     n.gain          = pwdata[7:0] & GAIN_MASK;
				IDX_BIAS:     n.bias          = pwdata[7:0] & BIAS_MASK;
				IDX_SYSCLK_RUNNING_FLAG:   n.sysclk_running_flag        = pwdata[0];
				default:      n.test          = s.test;
			endcase
		end

		if (s.fsm != FSM_IDLE) begin
			n.qcnt = qdone ? 9'h000 : s.qcnt + 9'h001;
		end

		unique case (s.fsm)
			FSM_IDLE: begin
				n.qcnt = 9'h000;
			end
			FSM_START: begin
				if (qdone) begin
					n.ph = s.ph + 2'h1;
					if (s.ph == 2'h3) begin
						n.fsm  = FSM_TX;
						n.bitn = 4'h0;
						if (s.step == STEP_FIRST) begin
							n.step = STEP_DEV_WR;
							n.sh   = {EE_DEVICE_CODE, loc[10:8], 1'b0};
						end else begin
							n.step = STEP_DATA1;
							n.sh   = {EE_DEVICE_CODE, loc[10:8], 1'b1};
						end
					end
				end
			end
			FSM_TX, FSM_RX: begin
				if (qdone) begin
					n.ph = s.ph + 2'h1;
					if (s.ph == 2'h1) begin
						if (s.fsm == FSM_TX && s.bitn != ACK_BIT) begin
							if (sda_s != s.sh[7]) begin
								err_set = 1'b1;
							end
						end else if (s.fsm == FSM_TX) begin
							if (sda_s) begin
								err_set = 1'b1;
							end
						end else if (s.bitn != ACK_BIT) begin
							n.sh = {s.sh[6:0], sda_s};
						end else if (sda_s != last_rx) begin
							err_set = 1'b1;
						end
						n.fail = s.fail | err_set;
					end
					if (s.ph == 2'h3) begin
						n.bitn = s.bitn + 4'h1;
						if (s.fsm == FSM_TX) begin
							n.sh = {s.sh[6:0], 1'b0};
						end
						if (s.fail) begin
							// an error ends the transfer with a stop condition
							n.fsm = FSM_STOP;
							n.ph  = 2'h0;
						end else if (s.bitn == ACK_BIT) begin
							n.bitn = 4'h0;
							n.ph   = 2'h0;
							unique case (s.step)
								STEP_DEV_WR: begin
									n.step = STEP_WORD;
									n.sh   = loc[7:0];
								end
								STEP_WORD: begin
									if (!s.op[0]) begin
										n.fsm  = FSM_START;
										n.step = STEP_DATA0;
									end else begin
										n.step = STEP_DATA0;
										n.sh   = s.op[1] ? s.gain : s.buffer;
									end
								end
								STEP_DATA0: begin
									n.step = STEP_DATA1;
									n.sh   = s.bias;
									if (!s.op[1]) begin
										n.fsm = FSM_STOP;
									end
								end
								STEP_DATA1: begin
									if (s.op[0]) begin
										n.fsm = FSM_STOP;
									end else begin
										n.fsm  = FSM_RX;
										n.step = STEP_RX0;
										n.sh   = 8'h00;
									end
								end
								STEP_RX0: begin
									if (s.op[1]) begin
										n.gain = s.sh & GAIN_MASK;
										n.step = STEP_RX1;
									end else begin
										n.buffer = s.sh;
										n.fsm    = FSM_STOP;
									end
								end
								default: begin
									n.bias = s.sh & BIAS_MASK;
									n.fsm  = FSM_STOP;
								end
							endcase
						end
					end
				end
			end
			FSM_STOP: begin
				if (qdone) begin
					n.ph = s.ph + 2'h1;
					if (s.ph == 2'h3) begin
						n.fsm  = FSM_IDLE;
						n.busy = 1'b0;
						n.fail = 1'b0;
						n.step = STEP_FIRST;
					end
				end
			end
			default: begin
				n.fsm  = FSM_IDLE;
				n.busy = 1'b0;
			end
		endcase

		if (start) begin
			n.fsm  = FSM_START;
			n.op   = op_t'(pwdata[1:0]);
			n.busy = 1'b1;
			n.ph   = 2'h0;
			n.qcnt = 9'h000;
			n.step = STEP_FIRST;
			n.fail = 1'b0;
		end
		// abort drops the link mid-byte; a memory write in flight may be torn
		if (abort) begin
			n.fsm  = FSM_IDLE;
			n.busy = 1'b0;
			n.fail = 1'b0;
			n.ph   = 2'h0;
			n.step = STEP_FIRST;
		end

		// the set wins over a clear in the same cycle
		n.err = (s.err & ~err_clr) | err_set;

		// line levels follow the next phase so they change with the phase flop
		unique case (n.fsm)
			FSM_START: begin
				n.scl = (n.ph == 2'h1) || (n.ph == 2'h2);
				drive = (n.ph == 2'h0) || (n.ph == 2'h1);
			end
			FSM_STOP: begin
				n.scl = (n.ph != 2'h0);
				drive = (n.ph == 2'h2) || (n.ph == 2'h3);
			end
			FSM_TX: begin
				n.scl = (n.ph == 2'h1) || (n.ph == 2'h2);
				drive = (n.bitn == ACK_BIT) ? 1'b1 : n.sh[7];
			end
			FSM_RX: begin
				n.scl = (n.ph == 2'h1) || (n.ph == 2'h2);
				drive = (n.bitn == ACK_BIT) ? ((n.step == STEP_RX1) || !n.op[1]) : 1'b1;
			end
			default: begin
				n.scl = 1'b1;
				drive = 1'b1;
			end
		endcase
		n.sda_oe = ~drive;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= STATE_RESET;
		end else begin
			s <= n;
		end
	end

	assign prdata      = {24'h000000, s.prdata};
	assign pready      = 1'b1;
	assign pslverr     = psel & penable & ~mapped;
	assign eeprom_link = '{clock_line: s.scl, data_out: 1'b0, data_oe: s.sda_oe};
	// gain codes map straight onto 1, 2, 4, 8 V/V in the analog block
	assign analog_cfg  = '{pre_gain: s.gain[3:2], adc_gain: s.gain[1:0],
		bias_switch_first: s.bias[5], bias_switch_second: s.bias[4],
		pre_bias: s.bias[3:0]};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	chk_start_busy: assert property (start |=> s.busy && s.fsm == FSM_START)
		else $error("accepted start did not raise busy");

	chk_abort_clears: assert property (abort |=> !s.busy && s.fsm == FSM_IDLE)
		else $error("abort did not clear busy at once");

	chk_abort_lines: assert property (abort |=> s.scl && !s.sda_oe)
		else $error("abort left the link lines driven");

	chk_err_clear: assert property (s.err && err_clr && !err_set |=> !s.err)
		else $error("error flag not cleared by write of one");

	chk_err_hold: assert property (s.err && !err_clr |=> s.err)
		else $error("error flag lost without a clear");

	chk_err_sets: assert property (err_set |=> s.err)
		else $error("detected link error not latched");

	chk_ctrl_read: assert property (psel && penable && !pwrite && paddr == {IDX_CTRL, 2'h0}
		|-> prdata[3:0] == 4'h0)
		else $error("strobe or mode bits read back nonzero");

	chk_busy_read: assert property (psel && !penable && paddr == {IDX_CTRL, 2'h0}
		|=> prdata[4] == $past(s.busy))
		else $error("busy bit read back wrong");

	chk_err_read: assert property (psel && !penable && paddr == {IDX_CTRL, 2'h0}
		|=> prdata[5] == $past(s.err))
		else $error("error bit read back wrong");

	chk_buffer_read: assert property (psel && !penable && paddr == {IDX_BUFFER, 2'h0}
		|=> prdata[7:0] == $past(s.buffer))
		else $error("buffer read back wrong");

	chk_start_gate: assert property (ctrl_w && pwdata[CTRL_START_BIT] && !s.sysclk_running_flag && !s.busy
		|=> !s.busy)
		else $error("start taken with system clock stopped");

	chk_busy_ignore: assert property (ctrl_w && pwdata[CTRL_START_BIT] && s.busy
		&& !pwdata[CTRL_ABORT_BIT] |=> s.op == $past(s.op))
		else $error("start during an access changed the mode");

	chk_idle_busy: assert property (s.fsm == FSM_IDLE |-> !s.busy)
		else $error("busy set while idle");

	chk_nack_error: assert property (s.fsm == FSM_TX && s.bitn == ACK_BIT && s.ph == 2'h1
		&& qdone && sda_s |=> s.err ##0 s.fail)
		else $error("missing acknowledge not flagged");

	chk_drive_mismatch: assert property (s.fsm == FSM_TX && s.bitn != ACK_BIT && s.ph == 2'h1
		&& qdone && sda_s != s.sh[7] |=> s.err)
		else $error("data line mismatch not flagged");

	chk_buffer_write: assert property (acc_w && idx == IDX_BUFFER && !s.busy && !start
		|=> s.buffer == $past(pwdata[7:0]))
		else $error("buffer did not keep written byte");

	chk_rx_store: assert property (s.fsm == FSM_RX && s.step == STEP_RX0 && !s.op[1]
		&& s.bitn == ACK_BIT && s.ph == 2'h3 && qdone && !s.fail && !abort
		|=> s.buffer == $past(s.sh))
		else $error("fetched byte not placed in buffer");

	chk_load_gain: assert property (s.fsm == FSM_RX && s.step == STEP_RX0 && s.op[1]
		&& s.bitn == ACK_BIT && s.ph == 2'h3 && qdone && !s.fail && !abort
		|=> s.gain == ($past(s.sh) & GAIN_MASK))
		else $error("loaded gain byte not applied");

	chk_dev_byte: assert property (s.fsm == FSM_START && s.ph == 2'h3 && qdone && !abort
		|=> s.fsm == FSM_TX && s.sh[7:4] == EE_DEVICE_CODE)
		else $error("device byte not loaded after start");

	chk_idle_lines: assert property (!s.busy && s.fsm == FSM_IDLE |-> s.scl && !s.sda_oe)
		else $error("lines not released while idle");

	chk_stop_lines: assert property (s.fsm == FSM_STOP && s.ph == 2'h3 |-> s.scl && !s.sda_oe)
		else $error("stop condition lines wrong");

	chk_start_clock: assert property (start |-> ##[1:400] !s.scl)
		else $error("clock line did not begin toggling");

	chk_stop_done: assert property (s.fsm == FSM_STOP && s.ph == 2'h3 && qdone && !abort
		&& !start |=> !s.busy)
		else $error("busy still set after stop");

endmodule // eeprom_master_access_ctrl

// ==== tb/eeprom_partner_model.sv ====
// Purpose: behavioural serial eeprom answering the two-wire master
// Assumes: data line has a pull-up, clock line is pushed by the master
// Notes: nak_all withholds every acknowledge so the error path can be provoked
`timescale 1ns/1ps
module eeprom_partner_model (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic nak_all,
	output logic      pull_low
);
	logic [7:0]  mem [0:2047];
	logic [7:0]  sh;
	logic [10:0] loc;
	logic        active;
	logic        rd;
	logic        nak;
	int          bitc;
	int          nb;
	initial begin
		pull_low = 0;
		active = 0;
		rd = 0;
		loc = '0;
	end
	// start resets the byte count; a repeated start keeps the location
	// the clock fall that ends the start condition is not a bit, so count from -1
	always @(negedge sda) if (scl) begin
		active = 1;
		bitc = -1;
		nb = 0;
		rd = 0;
		pull_low = 0;
	end
	always @(posedge sda) if (scl) active = 0;
	always @(posedge scl) if (active) begin
		if (bitc < 8 && !rd) sh = {sh[6:0], sda};
		if (bitc == 8) nak = sda;
	end
	// the line only changes while the clock is low, so no false start or stop
	always @(negedge scl) if (active) begin
		bitc = bitc + 1;
		if (bitc == 8 && !rd) begin
			if (nb == 0) begin
				rd = sh[0];
				loc[10:8] = sh[3:1];
			end else if (nb == 1) loc[7:0] = sh;
			else begin
				mem[loc] = sh;
				loc = loc + 1;
			end
			nb = nb + 1;
			pull_low = !nak_all;
		end else if (bitc == 8) begin
			pull_low = 0;
			loc = loc + 1;
		end else if (bitc == 9) begin
			bitc = 0;
			sh = mem[loc];
			pull_low = rd && !nak && !sh[7];
		end else if (rd) pull_low = !sh[7 - bitc];
	end
endmodule // eeprom_partner_model

// ==== tb/eeprom_master_access_ctrl_tb_top.sv ====
// Purpose: self-checking bench of the eeprom access controller over apb
// Assumes: pull-up on the data line, partner model as the memory
// Notes: bit time is fixed in the package, so only one write and one read run in full
`timescale 1ns/1ps
module eeprom_master_access_ctrl_tb_top;
	import eeprom_pkg::*;
	logic         clk;
	logic         resetn;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic         nak_all;
	logic         pready;
	logic         pslverr;
	logic         err_seen;
	logic         pull_low;
	logic         sda;
	logic [7:0]   paddr;
	logic [7:0]   b;
	logic [31:0]  pwdata;
	logic [31:0]  prdata;
	logic [31:0]  q;
	logic [31:0]  seed;
	eeprom_link_t link;
	analog_cfg_t  cfg;
	int           miscompares;
	int           n_tests;
	int           cyc;
	int           ref_reg [int];

	eeprom_master_access_ctrl eeprom_master_access_ctrl_i (.clk(clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .eeprom_data_line_in(sda),
		.eeprom_link(link), .analog_cfg(cfg));
	eeprom_partner_model eeprom_partner_model_i (.scl(link.clock_line), .sda(sda),
		.nak_all(nak_all), .pull_low(pull_low));
	assign sda = !(link.data_oe || pull_low);

	always #4 clk = ~clk;

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task summarize();
		if (miscompares == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		err_seen = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask

	// bench model keeps only the implemented bits of each register
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d);
		ref_reg[a] = d & (a == 8'h38 ? 'h0F : a == 8'h3C ? 'h3F : a == 8'h7C ? 1 : 'hFF);
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(0, a, 0);
		chk(nm, e, q);
	endtask

	task wait_idle();
		do apb(0, 8'h30, 0); while (q[4] !== 1'b0);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 120000) begin
			miscompares++;
			summarize();
		end
	end

	initial begin
		{clk, psel, penable, pwrite, nak_all, resetn} = 0;
		paddr = 0;
		pwdata = 0;
		seed = 80;
		{miscompares, n_tests, cyc} = 0;
		ref_reg = '{'h24:0, 'h28:0, 'h2C:0, 'h34:0, 'h38:0, 'h3C:0, 'h7C:1};
		repeat (6) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		// the factory test register is only ever read, never written
		foreach (ref_reg[a]) rd_chk(a[7:0], ref_reg[a], "reset value");
		rd_chk(8'h30, 0, "control idle");
		apb(0, 8'h40, 0);
		chk("unmapped error", 1, {31'h0, err_seen});
		chk("unmapped data", 0, q);
		for (int i = 0; i < 4; i++) begin
			wr(8'h38, xs());
			wr(8'h3C, xs());
			rd_chk(8'h38, ref_reg['h38], "gain");
			rd_chk(8'h3C, ref_reg['h3C], "bias");
			chk("analog cfg", ref_reg['h38] << 6 | ref_reg['h3C], {22'h0, cfg});
		end
		wr(8'h7C, 0);
		apb(1, 8'h30, 32'h04);
		rd_chk(8'h30, 0, "start without clock");
		wr(8'h7C, 1);
		// every mode is launched once and cut short; short runs keep the bench fast
		for (int m = 0; m < 4; m++) begin
			apb(1, 8'h30, 32'h04 | m);
			rd_chk(8'h30, 32'h10, "busy, strobes read zero");
			repeat (400) @(posedge clk);
			apb(1, 8'h30, 32'h08);
			rd_chk(8'h30, 0, "abort clears busy");
		end
		wr(8'h24, 32'h05);
		wr(8'h28, 32'h3C);
		b = xs();
		wr(8'h2C, {24'h0, b});
		apb(1, 8'h30, 32'h05);
		wait_idle();
		chk("memory byte", {24'h0, b}, {24'h0, eeprom_partner_model_i.mem[11'h53C]});
		rd_chk(8'h30, 0, "write no error");
		nak_all <= 1;
		apb(1, 8'h30, 32'h04);
		wait_idle();
		nak_all <= 0;
		rd_chk(8'h30, 32'h20, "nack error");
		apb(1, 8'h30, 0);
		rd_chk(8'h30, 32'h20, "error kept");
		apb(1, 8'h30, 32'h20);
		rd_chk(8'h30, 0, "error cleared");
		wr(8'h2C, {24'h0, ~b});
		apb(1, 8'h30, 32'h04);
		wait_idle();
		ref_reg['h2C] = b;
		rd_chk(8'h2C, ref_reg['h2C], "fetched byte");
		rd_chk(8'h30, 0, "read no error");
		summarize();
	end
endmodule // eeprom_master_access_ctrl_tb_top
